// [core/clock_select.sv]
// system clock source select, stop-mode clock enables and pll modulation control
//
// Function
// [R1] pll select 1: system clocks from pll output, bus clock at half rate.
// [R2] pll select 0 with oscillator qualified: clocks from oscillator, bus at half.
// [R3] clearing pll select is accepted only while oscillator is qualified.
// [R4] oscillator not qualified forces pll select to 1.
// [R5] entering full stop forces pll select to 1.
// [R6] pseudo stop bit keeps oscillator running in stop; 0 stops it.
// [R7] software waits oscillator start-up time before entering pseudo stop.
// [R8] rti runs in pseudo stop only with its enable and oscillator select set.
// [R9] otherwise rti counter freezes in stop, count kept.
// [R10] watchdog runs in pseudo stop only with its enable and oscillator select.
// [R11] otherwise watchdog counter freezes in stop, count kept.
// [R12] rti clock select: 1 oscillator clock, 0 internal reference clock.
// [R13] any change of rti clock select restarts the rti timeout.
// [R14] setting rti clock select accepted only while oscillator qualified.
// [R15] oscillator not qualified clears rti clock select.
// [R16] watchdog clock select: 1 oscillator clock, 0 internal reference clock.
// [R17] any change of watchdog clock select restarts the watchdog timeout.
// [R18] watchdog clock select set only while qualified, cleared when not.
// [R19] pll control holds modulation bits 5 and 4, others read 0, reset 0.
// [R20] modulation code 00 off, 01 1%, 10 2%, 11 4%, at reference/16.
// [R21] pll control write needs protect 0 and pll select 1, else ignored.
// [R22] accepted pll control write clears lock and qualified status.
// [R23] source select writes only while protect bit is 0.
// [R24] reserved bits ignore writes and read as 0.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps

module clock_select #(
    parameter int sync_stages = 3
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_select_pkg::addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status from the oscillator filter and pll, asynchronous
    input wire logic osc_good_pin,
    input wire logic pll_lock_pin,
    // stop request from the cpu, same clock
    input wire logic stop_request,
    // controls toward clock generators and timers
    output clock_select_pkg::clock_ctrl_s clock_ctrl
);

    typedef enum logic [1:0] {bus_idle, bus_wait, bus_done} bus_state_e;

    bus_state_e bus_state;
    logic [sync_stages-1:0] qual_sync;
    logic [sync_stages-1:0] lock_sync;
    logic qual_filt;
    logic lock_filt;
    logic qual_hold;
    logic lock_hold;
    logic qualified;
    logic locked;
    logic pll_select;
    logic pseudo_stop_select;
    logic rti_pseudo_stop_enable;
    logic watchdog_pseudo_stop_enable;
    logic rti_clock_select;
    logic watchdog_clock_select;
    logic register_protect;
    logic freq_mod_hi;
    logic freq_mod_lo;
    logic stop_active;
    logic full_stop;
    logic stop_entry;
    logic rti_sel_prev;
    logic wdg_sel_prev;
    logic osc_run;
    logic rti_run;
    logic wdg_run;
    logic rti_restart;
    logic wdg_restart;
    logic bus_clock_en;
    logic requalify;
    logic wr_commit;
    logic [7:0] reg_index;
    logic [7:0] wbyte;
    logic [7:0] next_rdata;
    logic next_err;

    // a register index is decoded here for writes only; reads decode it in the read mux
    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == clock_select_pkg::idx_source_select) ||
                 (idx == clock_select_pkg::idx_pll_control) ||
                 (idx == clock_select_pkg::idx_protect) ||
                 (idx == clock_select_pkg::idx_status);
    endfunction

    assign reg_index = paddr[9:2];
    assign wbyte = pwdata[7:0];
    // write lands at the edge where the master sees pready high
    assign wr_commit = ce && psel && penable && pwrite && pready &&
                       mapped(reg_index) && pstrb[0] && (paddr[1:0] == 2'h0);
    assign stop_entry = stop_request && !stop_active;

    // three-stage synchronisers; second and third must agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            qual_sync <= '0;
            lock_sync <= '0;
        end else if (ce) begin
            qual_sync <= {qual_sync[sync_stages-2:0], osc_good_pin};
            lock_sync <= {lock_sync[sync_stages-2:0], pll_lock_pin};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            qual_filt <= 1'b0;
            lock_filt <= 1'b0;
        end else if (ce) begin
            if (qual_sync[1] == qual_sync[2]) begin
                qual_filt <= qual_sync[2];
            end
            if (lock_sync[1] == lock_sync[2]) begin
                lock_filt <= lock_sync[2];
            end
        end
    end

    // a pll control write drops status until the filter re-reports it from low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            qual_hold <= 1'b0;
            lock_hold <= 1'b0;
        end else if (ce) begin
            if (wr_commit && reg_index == clock_select_pkg::idx_pll_control &&
                !register_protect && pll_select) begin
                qual_hold <= 1'b1; // [R22]
                lock_hold <= 1'b1; // [R22]
            end else begin
                if (!qual_filt) begin
                    qual_hold <= 1'b0;
                end
                if (!lock_filt) begin
                    lock_hold <= 1'b0;
                end
            end
        end
    end

    assign qualified = qual_filt && !qual_hold;
    assign locked = lock_filt && !lock_hold;

    // stop mode tracking
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_active <= 1'b0;
            full_stop <= 1'b0;
        end else if (ce) begin
            stop_active <= stop_request;
            if (stop_entry) begin
                full_stop <= !pseudo_stop_select; // [R6]
            end else if (!stop_request) begin
                full_stop <= 1'b0;
            end
        end
    end

    // source select register; forcing wins over software writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pll_select <= clock_select_pkg::rst_source_select[clock_select_pkg::pos_pll_select];
            pseudo_stop_select <=
                clock_select_pkg::rst_source_select[clock_select_pkg::pos_pseudo_stop];
            rti_pseudo_stop_enable <=
                clock_select_pkg::rst_source_select[clock_select_pkg::pos_rti_pseudo_stop];
            watchdog_pseudo_stop_enable <=
                clock_select_pkg::rst_source_select[clock_select_pkg::pos_wdg_pseudo_stop];
            rti_clock_select <=
                clock_select_pkg::rst_source_select[clock_select_pkg::pos_rti_clock];
            watchdog_clock_select <=
                clock_select_pkg::rst_source_select[clock_select_pkg::pos_wdg_clock];
        end else if (ce) begin
            if (wr_commit && reg_index == clock_select_pkg::idx_source_select &&
                !register_protect) begin // [R23]
                // bits 5 and 4 are not stored
                pll_select <= wbyte[clock_select_pkg::pos_pll_select] || !qualified; // [R3]
                pseudo_stop_select <= wbyte[clock_select_pkg::pos_pseudo_stop];
                rti_pseudo_stop_enable <= wbyte[clock_select_pkg::pos_rti_pseudo_stop];
                watchdog_pseudo_stop_enable <= wbyte[clock_select_pkg::pos_wdg_pseudo_stop];
                rti_clock_select <= wbyte[clock_select_pkg::pos_rti_clock] && qualified; // [R14]
                watchdog_clock_select <=
                    wbyte[clock_select_pkg::pos_wdg_clock] && qualified; // [R18]
            end
            if (!qualified) begin
                pll_select <= 1'b1; // [R4]
                rti_clock_select <= 1'b0; // [R15]
                watchdog_clock_select <= 1'b0; // [R18]
            end
            if (stop_entry && !pseudo_stop_select) begin
                pll_select <= 1'b1; // [R5]
            end
        end
    end

    // protect register of its own
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            register_protect <= clock_select_pkg::rst_protect;
        end else if (ce) begin
            if (wr_commit && reg_index == clock_select_pkg::idx_protect) begin
                register_protect <= wbyte[clock_select_pkg::pos_protect];
            end
        end
    end

    // pll modulation control; only bits 5 and 4 exist
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            freq_mod_hi <= clock_select_pkg::rst_pll_control[clock_select_pkg::pos_freq_mod_hi];
            freq_mod_lo <= clock_select_pkg::rst_pll_control[clock_select_pkg::pos_freq_mod_lo];
        end else if (ce) begin
            if (wr_commit && reg_index == clock_select_pkg::idx_pll_control &&
                !register_protect && pll_select) begin // [R21]
                freq_mod_hi <= wbyte[clock_select_pkg::pos_freq_mod_hi]; // [R19]
                freq_mod_lo <= wbyte[clock_select_pkg::pos_freq_mod_lo]; // [R19]
            end
        end
    end

    // requalify pulse tells the oscillator filter to start over
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            requalify <= 1'b0;
        end else if (ce) begin
            requalify <= wr_commit && reg_index == clock_select_pkg::idx_pll_control &&
                         !register_protect && pll_select; // [R22]
        end
    end

    // oscillator and timer clock enables; timers hold their count, never reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_run <= 1'b1;
            rti_run <= 1'b1;
            wdg_run <= 1'b1;
        end else if (ce) begin
            osc_run <= !stop_request || pseudo_stop_select; // [R6]
            rti_run <= !stop_request || // [R8] [R9]
                       (pseudo_stop_select && rti_pseudo_stop_enable && rti_clock_select);
            wdg_run <= !stop_request ||
                       (pseudo_stop_select && watchdog_pseudo_stop_enable &&
                        watchdog_clock_select); // [R10] [R11]
        end
    end

    // a change in either direction, written or forced, restarts the timeout
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rti_sel_prev <= clock_select_pkg::rst_source_select[clock_select_pkg::pos_rti_clock];
            wdg_sel_prev <= clock_select_pkg::rst_source_select[clock_select_pkg::pos_wdg_clock];
            rti_restart <= 1'b0;
            wdg_restart <= 1'b0;
        end else if (ce) begin
            rti_sel_prev <= rti_clock_select;
            wdg_sel_prev <= watchdog_clock_select;
            rti_restart <= rti_clock_select != rti_sel_prev; // [R13]
            wdg_restart <= watchdog_clock_select != wdg_sel_prev; // [R17]
        end
    end

    // bus clock enable: one system clock in bus_divide
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_clock_en <= 1'b0;
        end else if (ce) begin
            bus_clock_en <= !bus_clock_en; // [R1] [R2]
        end
    end

    // read mux and error decode
    always_comb begin
        next_rdata = 8'h00;
        next_err = 1'b0;
        case (reg_index)
            clock_select_pkg::idx_source_select: begin
                next_rdata[clock_select_pkg::pos_pll_select] = pll_select;
                next_rdata[clock_select_pkg::pos_pseudo_stop] = pseudo_stop_select;
                next_rdata[clock_select_pkg::pos_rti_pseudo_stop] = rti_pseudo_stop_enable;
                next_rdata[clock_select_pkg::pos_wdg_pseudo_stop] = watchdog_pseudo_stop_enable;
                next_rdata[clock_select_pkg::pos_rti_clock] = rti_clock_select;
                next_rdata[clock_select_pkg::pos_wdg_clock] = watchdog_clock_select; // [R24]
            end
            clock_select_pkg::idx_pll_control: begin
                next_rdata[clock_select_pkg::pos_freq_mod_hi] = freq_mod_hi;
                next_rdata[clock_select_pkg::pos_freq_mod_lo] = freq_mod_lo; // [R19] [R24]
            end
            clock_select_pkg::idx_protect: begin
                next_rdata[clock_select_pkg::pos_protect] = register_protect;
            end
            clock_select_pkg::idx_status: begin
                next_rdata[clock_select_pkg::pos_stat_qualified] = qualified;
                next_rdata[clock_select_pkg::pos_stat_lock] = locked;
                next_rdata[clock_select_pkg::pos_stat_stop] = stop_active;
                next_rdata[clock_select_pkg::pos_stat_full_stop] = full_stop;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
        if (paddr[1:0] != 2'h0) begin
            next_err = 1'b1;
        end
    end

    // apb handshake: pready rises in the second access cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_state <= bus_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            case (bus_state)
                bus_idle: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && !penable) begin
                        bus_state <= bus_wait;
                    end
                end
                bus_wait: begin
                    if (psel && penable) begin
                        bus_state <= bus_done;
                        pready <= 1'b1;
                        pslverr <= next_err;
                        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
                    end else if (!psel) begin
                        bus_state <= bus_idle;
                    end
                end
                bus_done: begin
                    // the transfer ends here; a following setup can start next edge
                    bus_state <= bus_idle;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    bus_state <= bus_idle;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    assign clock_ctrl.pll_select = pll_select; // [R1] [R2]
    assign clock_ctrl.osc_run = osc_run;
    assign clock_ctrl.rti_osc_select = rti_clock_select; // [R12]
    assign clock_ctrl.wdg_osc_select = watchdog_clock_select; // [R16]
    assign clock_ctrl.rti_run = rti_run;
    assign clock_ctrl.wdg_run = wdg_run;
    assign clock_ctrl.rti_restart = rti_restart;
    assign clock_ctrl.wdg_restart = wdg_restart;
    assign clock_ctrl.freq_mod = {freq_mod_hi, freq_mod_lo}; // [R20]
    assign clock_ctrl.bus_clock_en = bus_clock_en;
    assign clock_ctrl.requalify = requalify;

endmodule // clock_select

// [core/clock_select_pkg.sv]
// constants, types and register map of the system clock select block
package clock_select_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] idx_source_select = 8'h39;
    localparam logic [7:0] idx_pll_control = 8'h3a;
    localparam logic [7:0] idx_protect = 8'h3e;
    localparam logic [7:0] idx_status = 8'h3f;
    localparam int addr_width = 10;
    // source select field positions
    localparam int pos_pll_select = 7;
    localparam int pos_pseudo_stop = 6;
    localparam int pos_rti_pseudo_stop = 3;
    localparam int pos_wdg_pseudo_stop = 2;
    localparam int pos_rti_clock = 1;
    localparam int pos_wdg_clock = 0;
    // pll control field positions
    localparam int pos_freq_mod_hi = 5;
    localparam int pos_freq_mod_lo = 4;
    // protect and status field positions
    localparam int pos_protect = 0;
    localparam int pos_stat_qualified = 0;
    localparam int pos_stat_lock = 1;
    localparam int pos_stat_stop = 2;
    localparam int pos_stat_full_stop = 3;
    // reset values
    localparam logic [7:0] rst_source_select = 8'h80;
    localparam logic [7:0] rst_pll_control = 8'h00;
    localparam logic rst_protect = 1'b0;
    // frequency modulation amplitude codes, modulated at reference / 16
    localparam logic [1:0] fm_off = 2'h0;
    localparam logic [1:0] fm_one_pct = 2'h1;
    localparam logic [1:0] fm_two_pct = 2'h2;
    localparam logic [1:0] fm_four_pct = 2'h3;
    localparam int fm_mod_divide = 16;
    // bus clock is the system source divided by this
    localparam int bus_divide = 2;
    // outputs toward the clock generators and the timers
    typedef struct packed {
        logic pll_select;
        logic osc_run;
        logic rti_osc_select;
        logic wdg_osc_select;
        logic rti_run;
        logic wdg_run;
        logic rti_restart;
        logic wdg_restart;
        logic [1:0] freq_mod;
        logic bus_clock_en;
        logic requalify;
    } clock_ctrl_s;
endpackage

// [bench/clock_select_chk.sv]
// assertion checker for the clock select block
`timescale 1ns/10ps

module clock_select_chk #(
    parameter int sync_stages = 3
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_select_pkg::addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status and stop
    input wire logic osc_good_pin,
    input wire logic pll_lock_pin,
    input wire logic stop_request,
    // controls
    input wire clock_select_pkg::clock_ctrl_s clock_ctrl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence access_wait;
        ce && psel && penable && !pready;
    endsequence
    // eight low samples leave margin over the three-flop filter
    sequence osc_lost;
        (ce && !osc_good_pin) [*8];
    endsequence

    ready_after_access_a: assert property (access_wait |=> pready)
        else $error("no ready after access phase");
    ready_pulse_a: assert property (ce && pready |=> !pready)
        else $error("ready longer than one cycle");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    unqualified_force_a: assert property (
        osc_lost |-> clock_ctrl.pll_select && !clock_ctrl.rti_osc_select
            && !clock_ctrl.wdg_osc_select) else $error("selects not forced when unqualified");
    idle_enables_a: assert property (
        ce && !stop_request |=> clock_ctrl.osc_run && clock_ctrl.rti_run && clock_ctrl.wdg_run)
        else $error("enables low outside stop");
    full_stop_pll_a: assert property ($fell(clock_ctrl.osc_run) |-> clock_ctrl.pll_select)
        else $error("full stop did not force pll select");
    rti_freeze_a: assert property (
        ce && stop_request && !clock_ctrl.rti_osc_select |=> !clock_ctrl.rti_run)
        else $error("rti runs in stop on reference clock");
    wdg_freeze_a: assert property (
        ce && stop_request && !clock_ctrl.wdg_osc_select |=> !clock_ctrl.wdg_run)
        else $error("watchdog runs in stop on reference clock");
    rti_restart_a: assert property (
        ce && $changed(clock_ctrl.rti_osc_select) |=> clock_ctrl.rti_restart)
        else $error("rti restart missing");
    wdg_restart_a: assert property (
        ce && $changed(clock_ctrl.wdg_osc_select) |=> clock_ctrl.wdg_restart)
        else $error("watchdog restart missing");
    bus_toggle_a: assert property (ce |=> $changed(clock_ctrl.bus_clock_en))
        else $error("bus clock enable not toggling");
endmodule // clock_select_chk

bind clock_select clock_select_chk #(.sync_stages(sync_stages)) chk (.clk(clk), .reset(reset),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_good_pin(osc_good_pin), .pll_lock_pin(pll_lock_pin), .stop_request(stop_request),
    .clock_ctrl(clock_ctrl));

// [bench/clock_select_tb.sv]
// self-checking testbench for the clock select block
`timescale 1ns/10ps

module clock_select_tb;
    localparam logic [9:0] a_sel = {clock_select_pkg::idx_source_select, 2'h0};
    localparam logic [9:0] a_pll = {clock_select_pkg::idx_pll_control, 2'h0};
    localparam logic [9:0] a_register_protect = {clock_select_pkg::idx_protect, 2'h0};
    localparam logic [9:0] a_stat = {clock_select_pkg::idx_status, 2'h0};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic osc_good_pin = 1'b1;
    logic pll_lock_pin = 1'b1;
    logic stop_request = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    clock_select_pkg::clock_ctrl_s clock_ctrl;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 70687;
    logic [7:0] m_sel, rd, v, s;
    logic m_register_protect, q, err;
    logic [31:0] r;

    clock_select #(.sync_stages(3)) uut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_good_pin(osc_good_pin),
        .pll_lock_pin(pll_lock_pin), .stop_request(stop_request), .clock_ctrl(clock_ctrl));

    always #10 clk = ~clk;

    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; ready, read data and error are all taken at the edge that sees ready
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd,
                       input logic [3:0] st, output logic [7:0] rdat, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        // values read just after the edge are the ones the slave flops sampled there
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            final_report();
        end
        rdat = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] exp_sel(input logic [7:0] wd, input logic qual);
        logic [7:0] n;
        n = wd & 8'hcf;
        if (!qual) begin
            n[7] = 1'b1;
            n[1:0] = 2'h0;
        end
        return n;
    endfunction

    // pll select, oscillator run, rti run, watchdog run while stopped
    function automatic logic [7:0] exp_stop(input logic [7:0] c);
        return {4'h0, c[6] ? c[7] : 1'b1, c[6], c[6] & c[3] & c[1], c[6] & c[2] & c[0]};
    endfunction

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, a_sel, 8'h0, 4'h0, rd, err);
        check("sel reset", rd, clock_select_pkg::rst_source_select);
        bus(1'b0, a_pll, 8'h0, 4'h0, rd, err);
        check("pll reset", rd, 8'h00);
        m_sel = 8'h80;
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            q = (r[9:8] != 2'h0);
            osc_good_pin <= q;
            repeat (8) @(posedge clk);
            if (!q)
                m_sel = exp_sel(m_sel, 1'b0);
            m_register_protect = r[12] & r[13];
            bus(1'b1, a_register_protect, {7'h0, m_register_protect}, 4'h1, rd, err);
            // a clear byte strobe must leave the register alone
            bus(1'b1, a_sel, r[7:0], {3'h0, r[14] | r[15]}, rd, err);
            if (!m_register_protect && (r[14] | r[15]))
                m_sel = exp_sel(r[7:0], q);
            bus(1'b0, a_sel, 8'h0, 4'h0, rd, err);
            check("sel", rd, m_sel);
            check("read err", {7'h0, err}, 8'h00);
            @(negedge clk);
            v = {5'h0, clock_ctrl.pll_select, clock_ctrl.rti_osc_select,
                 clock_ctrl.wdg_osc_select};
            check("ctrl", v, {5'h0, m_sel[7], m_sel[1:0]});
            bus(1'b0, a_stat, 8'h0, 4'h0, rd, err);
            check("status", rd, {6'h0, 1'b1, q});
        end
        osc_good_pin <= 1'b1;
        bus(1'b1, a_register_protect, 8'h00, 4'h1, rd, err);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 8'h4f : (8'($random(seed)) & 8'hcf);
            bus(1'b1, a_sel, s, 4'h1, rd, err);
            stop_request <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            v = {4'h0, clock_ctrl.pll_select, clock_ctrl.osc_run, clock_ctrl.rti_run,
                 clock_ctrl.wdg_run};
            check("stop", v, exp_stop(s));
            bus(1'b0, a_stat, 8'h0, 4'h0, rd, err);
            check("stop status", rd, {4'h0, ~s[6], 3'h7});
            stop_request <= 1'b0;
            repeat (3) @(posedge clk);
        end
        bus(1'b1, a_sel, 8'h80, 4'h1, rd, err);
        bus(1'b1, a_pll, 8'hff, 4'h1, rd, err);
        bus(1'b0, a_pll, 8'h0, 4'h0, rd, err);
        check("pll", rd, 8'h30);
        bus(1'b0, a_stat, 8'h0, 4'h0, rd, err);
        check("status cleared", rd, 8'h00);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, a_pll, {2'h0, 2'(c), 4'h0}, 4'h1, rd, err);
            @(negedge clk);
            check("freq mod", {6'h0, clock_ctrl.freq_mod}, 8'(c));
            check("requalify", {7'h0, clock_ctrl.requalify}, 8'h01);
        end
        // status only comes back after both pins report low and then high
        osc_good_pin <= 1'b0;
        pll_lock_pin <= 1'b0;
        repeat (8) @(posedge clk);
        osc_good_pin <= 1'b1;
        pll_lock_pin <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b1, a_stat, 8'h00, 4'h1, rd, err);
        bus(1'b0, a_stat, 8'h0, 4'h0, rd, err);
        check("status back", rd, 8'h03);
        bus(1'b1, a_sel, 8'h00, 4'h1, rd, err);
        bus(1'b1, a_pll, 8'h10, 4'h1, rd, err);
        bus(1'b0, a_pll, 8'h0, 4'h0, rd, err);
        check("pll gated", rd, 8'h30);
        bus(1'b1, a_register_protect, 8'h01, 4'h1, rd, err);
        bus(1'b1, a_sel, 8'h83, 4'h1, rd, err);
        bus(1'b0, a_sel, 8'h0, 4'h0, rd, err);
        check("sel protected", rd, 8'h00);
        bus(1'b0, {8'h3b, 2'h0}, 8'h0, 4'h0, rd, err);
        check("unmapped err", {7'h0, err}, 8'h01);
        bus(1'b0, a_sel | 10'h1, 8'h0, 4'h0, rd, err);
        check("misaligned err", {7'h0, err}, 8'h01);
        // ce low freezes every flop; three edges would flip a running bus divider
        ce <= 1'b0;
        @(negedge clk);
        v = {7'h0, clock_ctrl.bus_clock_en};
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("ce freeze", {7'h0, clock_ctrl.bus_clock_en}, v);
        @(posedge clk);
        ce <= 1'b1;
        final_report();
    end
endmodule // clock_select_tb
